// ==== hw/crc16_byte_engine.sv ====
/*
  byte-wide crc16 engine with its register port: input byte, checksum
  pair, control and a fold counter. assumes a master that pulses one
  strobe per cycle and takes read data in the following cycle.
*/
// Local design decisions: the register offsets and the strobed register port.
// Operation
// - select 0 ccitt, select 1 crc-16
// - only these two generators are selectable
// - feedback 8005h for crc-16, 1021h ccitt
// - input write folds byte into checksum pair
// - update finishes within one cycle
// - start with input xor checksum high byte
// - shift left one, zero into lsb
// - xor feedback only when tested bit set
// - eight steps per byte give new checksum
// - checksum pair readable writable, resets zero
// - input byte register eight bits, resets zero
// - control bits 7..1 read zero, bit0 select
module crc16_byte_engine
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic [15:0] running_checksum_out,
  output logic generator_select_out
);

  logic [7:0] input_byte_reg;
  logic [7:0] checksum_low_reg;
  logic [7:0] checksum_high_reg;
  logic generator_select;
  logic [15:0] fold_count;
  logic [15:0] folded;
  logic [7:0] next_rdata;

  // address decode
  wire hit_input = reg_addr_in == crc16_pkg::INPUT_BYTE_OFS;
  wire hit_low = reg_addr_in == crc16_pkg::CHECKSUM_LOW_OFS;
  wire hit_high = reg_addr_in == crc16_pkg::CHECKSUM_HIGH_OFS;
  wire hit_control = reg_addr_in == crc16_pkg::CONTROL_OFS;
  wire hit_count_low = reg_addr_in == crc16_pkg::FOLD_COUNT_LOW_OFS;
  wire hit_count_high = reg_addr_in == crc16_pkg::FOLD_COUNT_HIGH_OFS;

  wire wr_input = reg_wr_in & hit_input;
  wire wr_low = reg_wr_in & hit_low;
  wire wr_high = reg_wr_in & hit_high;
  wire wr_control = reg_wr_in & hit_control;

  wire [15:0] checksum = {checksum_high_reg, checksum_low_reg};
  wire [7:0] control_view = {7'h00, generator_select};

  // the fold is combinational so the pair updates on the write edge
  crc_byte_fold u_fold
  (
    .checksum_in(checksum),
    .data_in(reg_wdata_in),
    .generator_select_in(generator_select),
    .next_checksum_out(folded)
  );

  byte_store u_low
  (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .sw_load_in(wr_low),
    .sw_data_in(reg_wdata_in),
    .hw_load_in(wr_input),
    .hw_data_in(folded[7:0]),
    .value_out(checksum_low_reg)
  );

  byte_store u_high
  (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .sw_load_in(wr_high),
    .sw_data_in(reg_wdata_in),
    .hw_load_in(wr_input),
    .hw_data_in(folded[15:8]),
    .value_out(checksum_high_reg)
  );

  // read mux: unmapped addresses answer zero
  assign next_rdata = !reg_rd_in ? crc16_pkg::READ_ZERO :
                      hit_input ? input_byte_reg :
                      hit_low ? checksum_low_reg :
                      hit_high ? checksum_high_reg :
                      hit_control ? control_view :
                      hit_count_low ? fold_count[7:0] :
                      hit_count_high ? fold_count[15:8] :
                      crc16_pkg::READ_ZERO;

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      input_byte_reg <= crc16_pkg::BYTE_RESET;
    end
    else if (wr_input)
    begin
      input_byte_reg <= reg_wdata_in;
    end
  end

  // select taken between bytes only; a change mid-stream is software's risk
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      generator_select <= crc16_pkg::SELECT_CCITT;
    end
    else if (wr_control)
    begin
      generator_select <= reg_wdata_in[crc16_pkg::SELECT_BIT];
    end
  end

  // counts folded bytes; a checksum load restarts it, wraps at 16 bits
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      fold_count <= crc16_pkg::COUNT_RESET;
    end
    else if (wr_low | wr_high)
    begin
      fold_count <= crc16_pkg::COUNT_RESET;
    end
    else if (wr_input)
    begin
      fold_count <= fold_count + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      reg_rdata_out <= crc16_pkg::READ_ZERO;
      running_checksum_out <= crc16_pkg::COUNT_RESET;
      generator_select_out <= crc16_pkg::SELECT_CCITT;
    end
    else
    begin
      reg_rdata_out <= next_rdata;
      running_checksum_out <= checksum;
      generator_select_out <= generator_select;
    end
  end

endmodule // crc16_byte_engine

// ==== hw/crc16_pkg.sv ====
/*
  shared constants of the byte-wide crc16 engine: register offsets,
  field positions, reset values and feedback constants.
  assumes an 8-bit register port with byte-sized registers.
*/
package crc16_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CRC_W = 16;
  localparam int unsigned BITS_PER_BYTE = 8;

  localparam logic [7:0] INPUT_BYTE_OFS = 8'h00;
  localparam logic [7:0] CHECKSUM_LOW_OFS = 8'h01;
  localparam logic [7:0] CHECKSUM_HIGH_OFS = 8'h02;
  localparam logic [7:0] CONTROL_OFS = 8'h03;
  localparam logic [7:0] FOLD_COUNT_LOW_OFS = 8'h04;
  localparam logic [7:0] FOLD_COUNT_HIGH_OFS = 8'h05;

  localparam int unsigned SELECT_BIT = 0;
  localparam logic SELECT_CCITT = 1'b0;
  localparam logic SELECT_CRC16 = 1'b1;

  localparam logic [15:0] CCITT_FEEDBACK = 16'h1021;
  localparam logic [15:0] CRC16_FEEDBACK = 16'h8005;

  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] READ_ZERO = 8'h00;

endpackage

// ==== hw/byte_store.sv ====
/*
  one 8-bit register with a direct software load and a hardware update.
  assumes the two load requests are never needed at once; the software
  load takes priority if they meet.
*/
module byte_store
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic sw_load_in,
  input wire logic [7:0] sw_data_in,
  input wire logic hw_load_in,
  input wire logic [7:0] hw_data_in,
  output logic [7:0] value_out
);

  logic [7:0] next_value;

  assign next_value = sw_load_in ? sw_data_in :
                      hw_load_in ? hw_data_in : value_out;

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      value_out <= crc16_pkg::BYTE_RESET;
    end
    else
    begin
      value_out <= next_value;
    end
  end

endmodule // byte_store

// ==== hw/crc_byte_fold.sv ====
/*
  combinational fold of one input byte into a 16-bit checksum,
  msb first and not reflected. assumes the caller registers the result.
*/
module crc_byte_fold
(
  input wire logic [15:0] checksum_in,
  input wire logic [7:0] data_in,
  input wire logic generator_select_in,
  output logic [15:0] next_checksum_out
);

  // only two generators exist; any select value maps to one of them
  function automatic logic [15:0] feedback_of(input logic sel);
    feedback_of = (sel == crc16_pkg::SELECT_CRC16) ?
                  crc16_pkg::CRC16_FEEDBACK :
                  crc16_pkg::CCITT_FEEDBACK;
  endfunction

  // one shift step; the bit leaving position 15 decides the feedback
  function automatic logic [15:0] step(input logic [15:0] v,
                                       input logic [15:0] fb);
    logic [15:0] shifted;
    shifted = {v[14:0], 1'b0};
    step = v[15] ? (shifted ^ fb) : shifted;
  endfunction

  logic [15:0] feedback;
  logic [15:0] temp_start;

  assign feedback = feedback_of(generator_select_in);
  assign temp_start = {checksum_in[15:8] ^ data_in, checksum_in[7:0]};

  always_comb
  begin
    next_checksum_out = temp_start;
    for (int i = 0; i < crc16_pkg::BITS_PER_BYTE; i++)
    begin
      next_checksum_out = step(next_checksum_out, feedback);
    end
  end

endmodule // crc_byte_fold

// ==== dv/crc16_props.sv ====
/*
  port checker of the crc16 register engine.
  assumes a bind to crc16_byte_engine.
*/
module crc16_props
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [15:0] running_checksum_out,
  input wire logic generator_select_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  rd_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not idle");
  ctrl_rd_a: assert property ($past(reg_rd_in && reg_addr_in == 8'h03)
    |-> reg_rdata_out[7:1] == 7'h00) else $error("control spare bits set");
  in_rd_a: assert property (reg_wr_in && reg_addr_in == 8'h00 ##1
    reg_rd_in && reg_addr_in == 8'h00 |=> reg_rdata_out ==
    $past(reg_wdata_in, 2)) else $error("input byte lost");
  sel_a: assert property (reg_wr_in && reg_addr_in == 8'h03 |-> ##2
    generator_select_out == $past(reg_wdata_in[0], 2))
    else $error("select not stored");
  lo_load_a: assert property (reg_wr_in && reg_addr_in == 8'h01 |-> ##2
    running_checksum_out[7:0] == $past(reg_wdata_in, 2))
    else $error("low byte not loaded");
  hi_load_a: assert property (reg_wr_in && reg_addr_in == 8'h02 |-> ##2
    running_checksum_out[15:8] == $past(reg_wdata_in, 2))
    else $error("high byte not loaded");
  sum_why_a: assert property ($changed(running_checksum_out)
    |-> $past(reg_wr_in, 2)) else $error("checksum moved unasked");
  fold_one_a: assert property (reg_wr_in && reg_addr_in == 8'h01 &&
    reg_wdata_in == 8'h00 ##1 reg_wr_in && reg_addr_in == 8'h02 &&
    reg_wdata_in == 8'h00 ##1 reg_wr_in && reg_addr_in == 8'h00 &&
    reg_wdata_in == 8'h01 |-> ##2 running_checksum_out ==
    (generator_select_out ? 16'h8005 : 16'h1021)) else $error("bad fold");
endmodule // crc16_props

// ==== dv/tb_top.sv ====
/*
  self-checking bench of the crc16 register engine.
  assumes read data one cycle after the read strobe.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic [15:0] running_checksum_out;
  logic generator_select_out;
  int err_total = 0;
  int tests_run = 0;
  crc16_byte_engine i_crc16_byte_engine
  (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .running_checksum_out(running_checksum_out),
    .generator_select_out(generator_select_out)
  );
  initial
  begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // strobes stay up between calls so no signal is assigned twice a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_rd_in <= 1'b0;
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    #1;
    chk(reg_rdata_out, e);
  endtask
  task automatic idle(input int n);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    repeat (n) @(posedge sys_clk_in);
  endtask
  function automatic logic [15:0] crc(input logic [15:0] c,
    input logic [7:0] d, input logic s);
    c = c ^ {d, 8'h00};
    repeat (8) c = c[15] ? (c << 1) ^ (s ? 16'h8005 : 16'h1021) : c << 1;
    return c;
  endfunction
  task automatic rst;
    srst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    for (int a = 0; a < 6; a++) rd(a[7:0], 16'h0000);
    rd(8'h40, 16'h0000);
    idle(1);
  endtask
  task automatic t_single;
    for (int s = 0; s < 2; s++)
      for (int d = 0; d < 8; d++)
      begin
        wr(8'h03, {7'h7f, s[0]});
        wr(8'h01, 8'h00);
        wr(8'h02, 8'h00);
        wr(8'h00, d[7:0]);
        idle(2);
        chk(running_checksum_out, crc(16'h0000, d[7:0], s[0]));
        chk({15'h0000, generator_select_out}, {15'h0000, s[0]});
        rd(8'h03, {15'h0000, s[0]});
      end
  endtask
  task automatic t_seq;
    for (int s = 0; s < 2; s++)
    begin
      wr(8'h03, {7'h00, s[0]});
      wr(8'h01, 8'h00);
      wr(8'h02, 8'h00);
      wr(8'h00, 8'h78);
      wr(8'h00, 8'h56);
      wr(8'h00, 8'h34);
      wr(8'h00, 8'h12);
      rd(8'h00, 16'h0012);
      rd(8'h04, 16'h0004);
      rd(8'h05, 16'h0000);
      idle(2);
      chk(running_checksum_out, s ? 16'h5c43 : 16'hd0fa);
      rd(8'h02, s ? 16'h005c : 16'h00d0);
      rd(8'h01, s ? 16'h0043 : 16'h00fa);
    end
  endtask
  task automatic t_seed;
    logic [15:0] e;
    e = crc(16'h1234, 8'hab, 1'b1);
    wr(8'h03, 8'h01);
    wr(8'h01, 8'h34);
    wr(8'h02, 8'h12);
    wr(8'h40, 8'hff);
    wr(8'h04, 8'hff);
    idle(2);
    chk(running_checksum_out, 16'h1234);
    wr(8'h00, 8'hab);
    rd(8'h02, {8'h00, e[15:8]});
    rd(8'h01, {8'h00, e[7:0]});
    rd(8'h04, 16'h0001);
  endtask
  task automatic end_sim;
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    err_total++;
    end_sim();
  end
  initial
  begin
    rst();
    t_single();
    t_seq();
    rst();
    t_seed();
    idle(2);
    end_sim();
  end
endmodule // tb_top
bind crc16_byte_engine crc16_props i_crc16_props
(
  .sys_clk_in(sys_clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .running_checksum_out(running_checksum_out),
  .generator_select_out(generator_select_out)
);
